// ### ccp_core.sv
// coulomb counter current path with ahb-lite register slave
//
// Overview of operation
// [RULE1] report positive current when sense input lies below ground
// [RULE2] refresh current once per 878 ms period with the period average
// [RULE3] clamp current result at 7FFFh on charge overflow
// [RULE4] clamp current result at 8000h on discharge underflow
// [RULE5] every 1024th conversion measures the converter offset instead
// [RULE6] offset correction applies to the following 1023 measurements
// [RULE7] during offset conversion hold and re-accumulate the previous current
// [RULE8] add signed contribution to the up/down accumulator each period end
// [RULE9] accumulator spans 0 to 409.6 mVh, lsb 6.25 uVh
// [RULE10] hidden fractional accumulator bits, not host accessible
// [RULE11] accumulator clamps at FFFFh and 0000h, never wraps
// [RULE12] host accumulator write clears fractional bits
// [RULE13] host accumulator write starts an immediate offset conversion
// [RULE14] after write, accumulation restarts with the second conversion
// [RULE15] add current offset bias to raw result; reported and accumulated
// [RULE16] offset bias 1.56 uV steps, +198 to -200 uV, next sample
// [RULE17] offset bias volatile two's complement; host rewrites after power-up
// [RULE18] always blank charge currents below 100 uV from accumulation
// [RULE19] blank discharge below 25 uV magnitude only when enable set
// [RULE20] accumulator adds current plus accumulation bias; bias never blanked
// [RULE21] accumulation bias 6.25 uV steps, two low bits ignored
// [RULE22] accumulation bias volatile two's complement; host initialises it
// [RULE23] sleep pauses conversions and keeps the accumulator
// [RULE24] discharge blank enable comes up set after reset
// [RULE25] blanking, bias and saturating add happen in one update step
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module ccp_core
  import ccp_pkg::*;
#(
  parameter int PERIOD_CYC = ccp_pkg::CONV_PERIOD_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ccp_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // current converter
  output logic conv_start,
  output logic conv_offset,
  input wire ccp_pkg::ccp_conv_res_t conv_res,
  // power mode pin
  input wire logic sleep_req
);
  import ccp_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  ccp_state_t state;
  logic asleep;
  logic [31:0] period_cnt;
  logic tick;
  logic tick_pend;
  logic pend_off;
  logic skip_acc;
  logic discard;
  logic [CNT_W-1:0] conv_cnt;
  logic [SAMPLE_W-1:0] offset_corr;
  logic [CUR_W-1:0] current;
  logic [ACR_W-1:0] charge_accumulator;
  logic [FRAC_W-1:0] frac;
  logic [BIAS_W-1:0] current_offset_bias;
  logic [BIAS_W-1:0] accumulation_bias;
  logic [7:0] config_reg;
  logic dp_read;
  logic dp_write;
  logic dp_ok;
  logic [7:0] dp_idx;
  logic rd_ready;

  // ****************************************
  // bus decode
  // ****************************************
  wire ap_valid = hsel && htrans[1] && hready;
  wire ap_ok = (haddr[1:0] == 2'h0) && (haddr[ADDR_W-1:10] == '0) && (hsize == HSIZE_WORD);
  wire wr_en = dp_write && hready && dp_ok;
  wire acr_wr = wr_en && (dp_idx == IDX_ACR);
  wire current_offset_bias_wr = wr_en && (dp_idx == IDX_CURRENT_OFFSET_BIAS);
  wire abr_wr = wr_en && (dp_idx == IDX_ABR);
  wire cfg_wr = wr_en && (dp_idx == IDX_CONFIG);
  wire discharge_blank_enable = config_reg[CFG_DISCHARGE_BLANK_ENABLE_BIT];
  wire [31:0] rd_mux =
    !dp_ok ? 32'h0000_0000 :
    (dp_idx == IDX_CONFIG) ? {24'h00_0000, config_reg} :
    (dp_idx == IDX_CURRENT) ? {16'h0000, current} :
    (dp_idx == IDX_ACR) ? {16'h0000, charge_accumulator} :
    (dp_idx == IDX_CURRENT_OFFSET_BIAS) ? {24'h00_0000, current_offset_bias} :
    (dp_idx == IDX_ABR) ? {24'h00_0000, accumulation_bias} : 32'h0000_0000;

  assign hreadyout = !dp_read || rd_ready;
  assign hresp = 1'b0;

  // ****************************************
  // conversion scheduling
  // ****************************************
  wire launch = (state == CCP_IDLE) && !asleep && (pend_off || tick_pend); // [RULE23]
  wire launch_off = pend_off || (conv_cnt == CNT_W'(OFFSET_EVERY - 1)); // [RULE5] [RULE13]
  wire done_ok = conv_res.done && (state != CCP_IDLE);
  wire upd_meas = done_ok && (state == CCP_MEAS) && !discard;
  wire upd_offs = done_ok && (state == CCP_OFFS) && !discard;
  wire acc_upd = upd_meas || (upd_offs && !skip_acc); // [RULE7] [RULE14] [RULE25]

  assign tick = (period_cnt == 32'(PERIOD_CYC - 1)) && !asleep; // [RULE2]

  // ****************************************
  // current result path
  // ****************************************
  wire signed [SAMPLE_W:0] diff =
    $signed({conv_res.data[SAMPLE_W-1], conv_res.data}) -
    $signed({offset_corr[SAMPLE_W-1], offset_corr}); // [RULE6]
  // sense below ground reads as a negative conversion, so negate it
  wire signed [SAMPLE_W+1:0] cur_pre =
    $signed({(SAMPLE_W+2){1'b0}}) - $signed({diff[SAMPLE_W], diff}) +
    $signed({{(SAMPLE_W+2-BIAS_W){current_offset_bias[BIAS_W-1]}}, current_offset_bias}); // [RULE1] [RULE15]
  logic [CUR_W-1:0] cur_sat;
  logic cur_hi;
  logic cur_lo;

  ccp_sat #(
    .IN_W(SAMPLE_W + 2),
    .OUT_W(CUR_W),
    .SIGNED_OUT(1'b1)
  ) u_cur_sat (
    .din(cur_pre),
    .dout(cur_sat),
    .sat_hi(cur_hi),
    .sat_lo(cur_lo)
  ); // [RULE3] [RULE4]

  // ****************************************
  // accumulation path
  // ****************************************
  wire [CUR_W-1:0] meas_val = upd_meas ? cur_sat : current; // [RULE7]
  wire signed [CUR_W-1:0] meas_s = $signed(meas_val);
  wire blank_chg = (meas_s > 0) && (meas_s < CUR_W'(CHG_BLANK_LSB)); // [RULE18]
  wire blank_dis = discharge_blank_enable && (meas_s < 0) && (meas_s > -CUR_W'(DIS_BLANK_LSB)); // [RULE19]
  wire [BIAS_W-1:0] abr_eff = accumulation_bias & ABR_USED_MASK; // [RULE21]
  localparam int ACC_W = ACR_W + FRAC_W + 2;
  wire signed [ACC_W-1:0] meas_ext = (blank_chg || blank_dis) ? '0 :
    $signed({{(ACC_W-CUR_W){meas_val[CUR_W-1]}}, meas_val});
  wire signed [ACC_W-1:0] abr_ext = $signed({{(ACC_W-BIAS_W){abr_eff[BIAS_W-1]}}, abr_eff});
  wire signed [ACC_W-1:0] acc_sum =
    $signed({2'b00, charge_accumulator, frac}) + meas_ext + abr_ext; // [RULE8] [RULE20]
  logic [ACR_W+FRAC_W-1:0] acc_sat;
  logic acc_hi;
  logic acc_lo;

  ccp_sat #(
    .IN_W(ACC_W),
    .OUT_W(ACR_W + FRAC_W),
    .SIGNED_OUT(1'b0)
  ) u_acc_sat (
    .din(acc_sum),
    .dout(acc_sat),
    .sat_hi(acc_hi),
    .sat_lo(acc_lo)
  ); // [RULE11]

  // ****************************************
  // sleep input
  // ****************************************
  ccp_sync u_sleep_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(sleep_req),
    .dout(asleep)
  );

  // ****************************************
  // ahb-lite data phase
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_read <= 1'b0;
      dp_write <= 1'b0;
      dp_ok <= 1'b0;
      dp_idx <= 8'h00;
      rd_ready <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      dp_read <= ap_valid && !hwrite;
      dp_write <= ap_valid && hwrite;
      dp_ok <= ap_ok;
      dp_idx <= haddr[9:2];
      rd_ready <= 1'b0;
    end else if (dp_read) begin
      rd_ready <= 1'b1;
      hrdata <= rd_mux;
    end
  end

  // ****************************************
  // host registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      current_offset_bias <= 8'h00; // [RULE17]
      accumulation_bias <= 8'h00; // [RULE22]
      config_reg <= CFG_RESET; // [RULE24]
    end else begin
      if (current_offset_bias_wr) current_offset_bias <= hwdata[BIAS_W-1:0]; // [RULE16]
      if (abr_wr) accumulation_bias <= hwdata[BIAS_W-1:0]; // [RULE21]
      if (cfg_wr) config_reg <= hwdata[7:0] & CFG_RESET;
    end
  end

  // ****************************************
  // period divider
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_cnt <= 32'h0000_0000;
      tick_pend <= 1'b0;
    end else if (acr_wr) begin
      period_cnt <= 32'h0000_0000;
      tick_pend <= 1'b0;
    end else begin
      if (tick) period_cnt <= 32'h0000_0000;
      else if (!asleep) period_cnt <= period_cnt + 32'h0000_0001;
      if (tick) tick_pend <= 1'b1;
      else if (launch) tick_pend <= 1'b0;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CCP_IDLE;
      conv_cnt <= '0;
      conv_start <= 1'b0;
      conv_offset <= 1'b0;
      skip_acc <= 1'b0;
    end else begin
      conv_start <= launch;
      case (state)
        CCP_IDLE: begin
          if (launch) begin
            state <= launch_off ? CCP_OFFS : CCP_MEAS;
            conv_offset <= launch_off;
            skip_acc <= pend_off; // [RULE14]
            conv_cnt <= launch_off ? '0 : conv_cnt + CNT_W'(1); // [RULE5]
          end
        end
        CCP_MEAS, CCP_OFFS: begin
          if (conv_res.done) state <= CCP_IDLE;
        end
        default: state <= CCP_IDLE;
      endcase
    end
  end

  // ****************************************
  // pending offset and discard flags
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_off <= 1'b0;
      discard <= 1'b0;
    end else begin
      if (acr_wr) pend_off <= 1'b1; // [RULE13]
      else if (launch) pend_off <= 1'b0;
      if (acr_wr && (launch || ((state != CCP_IDLE) && !done_ok))) discard <= 1'b1;
      else if (done_ok) discard <= 1'b0;
    end
  end

  // ****************************************
  // results and accumulator
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      offset_corr <= '0;
      current <= '0;
    end else begin
      if (upd_offs) offset_corr <= conv_res.data; // [RULE6]
      if (upd_meas) current <= cur_sat; // [RULE2] [RULE15]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      charge_accumulator <= ACR_MIN;
      frac <= '0;
    end else if (acr_wr) begin
      charge_accumulator <= hwdata[ACR_W-1:0];
      frac <= '0; // [RULE12]
    end else if (acc_upd) begin
      {charge_accumulator, frac} <= acc_sat; // [RULE8] [RULE9] [RULE10]
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_acr_write;
    acr_wr && (state == CCP_IDLE) && !asleep && !launch;
  endsequence

  sequence s_offset_launch;
    conv_start && conv_offset;
  endsequence

  AST_CUR_SIGN: assert property ( // [RULE1]
    upd_meas && (current_offset_bias == 8'h00) && !cur_hi && !cur_lo &&
    ($signed(conv_res.data) > $signed(offset_corr)) |=> $signed(current) < 0)
    else $error("sense above ground did not give a negative current");

  AST_CUR_SAT_HI: assert property ( // [RULE3]
    upd_meas && cur_hi |=> current == CUR_MAX)
    else $error("current did not clamp at the maximum");

  AST_CUR_SAT_LO: assert property ( // [RULE4]
    upd_meas && cur_lo |=> current == CUR_MIN)
    else $error("current did not clamp at the minimum");

  AST_OFFSET_SLOT: assert property ( // [RULE5]
    launch && !pend_off && (conv_cnt != CNT_W'(OFFSET_EVERY - 1))
    |=> conv_start && !conv_offset)
    else $error("offset conversion outside its slot");

  AST_OFFS_HOLD: assert property ( // [RULE7]
    upd_offs && !acr_wr |=> $stable(current) && (offset_corr == $past(conv_res.data)))
    else $error("offset conversion changed current or missed the correction");

  AST_ACR_CLAMP: assert property ( // [RULE11]
    acc_upd && !acr_wr && acc_hi |=> (charge_accumulator == ACR_MAX) && (frac == '1))
    else $error("accumulator wrapped above full scale");

  AST_FRAC_CLEAR: assert property ( // [RULE12]
    acr_wr |=> (frac == '0) && (charge_accumulator == $past(hwdata[ACR_W-1:0])))
    else $error("accumulator write kept fractional bits");

  AST_WRITE_OFFSET: assert property ( // [RULE13]
    s_acr_write |-> ##2 s_offset_launch)
    else $error("accumulator write did not start an offset conversion");

  AST_FORCED_SKIP: assert property ( // [RULE14]
    upd_offs && skip_acc && !acr_wr |=> $stable({charge_accumulator, frac}))
    else $error("forced offset conversion was accumulated");

  AST_CHG_BLANK: assert property ( // [RULE18]
    acc_upd && !acr_wr && blank_chg && (abr_eff == 8'h00) |=> $stable({charge_accumulator, frac}))
    else $error("small charge current was accumulated");

  AST_SLEEP_PAUSE: assert property ( // [RULE23]
    asleep && !pend_off && !acr_wr && (state == CCP_IDLE) |=> !conv_start)
    else $error("conversion started while asleep");

endmodule : ccp_core

// ### ccp_pkg.sv
// shared constants and types for the coulomb counter current path
package ccp_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CONV_PERIOD_MS = 878;
  localparam int CONV_PERIOD_CYC = CONV_PERIOD_MS * (CLK_FREQ_HZ / 1000);
  localparam int OFFSET_EVERY = 1024;
  localparam int CNT_W = 10;

  // ****************************************
  // data widths
  // ****************************************
  localparam int SAMPLE_W = 16;
  localparam int CUR_W = 16;
  localparam int ACR_W = 16;
  localparam int FRAC_W = 14;
  localparam int BIAS_W = 8;

  // ****************************************
  // scaling and thresholds (current lsb 1.5625 uV)
  // ****************************************
  localparam int CUR_LSB_PV = 1_562_500;
  localparam int CHG_BLANK_UV = 100;
  localparam int DIS_BLANK_UV = 25;
  localparam int CHG_BLANK_LSB = CHG_BLANK_UV * 1_000_000 / CUR_LSB_PV;
  localparam int DIS_BLANK_LSB = DIS_BLANK_UV * 1_000_000 / CUR_LSB_PV;
  localparam logic [BIAS_W-1:0] ABR_USED_MASK = 8'hFC;
  localparam logic [CUR_W-1:0] CUR_MAX = 16'h7FFF;
  localparam logic [CUR_W-1:0] CUR_MIN = 16'h8000;
  localparam logic [ACR_W-1:0] ACR_MAX = 16'hFFFF;
  localparam logic [ACR_W-1:0] ACR_MIN = 16'h0000;

  // ****************************************
  // register map: index, byte address is index times four
  // ****************************************
  localparam logic [7:0] IDX_CONFIG = 8'h01;
  localparam logic [7:0] IDX_CURRENT = 8'h0E;
  localparam logic [7:0] IDX_ACR = 8'h10;
  localparam logic [7:0] IDX_CURRENT_OFFSET_BIAS = 8'h61;
  localparam logic [7:0] IDX_ABR = 8'h62;
  localparam int ADDR_W = 12;
  localparam int CFG_DISCHARGE_BLANK_ENABLE_BIT = 4;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic done;
    logic [SAMPLE_W-1:0] data;
  } ccp_conv_res_t;

  typedef enum logic [1:0] {
    CCP_IDLE = 2'h0,
    CCP_MEAS = 2'h1,
    CCP_OFFS = 2'h3
  } ccp_state_t;

endpackage : ccp_pkg

// ### ccp_sat.sv
// saturating width reduction, signed or unsigned result
`timescale 1ns/1ps
module ccp_sat #(
  parameter int IN_W = 18,
  parameter int OUT_W = 16,
  parameter bit SIGNED_OUT = 1'b1
) (
  // value in
  input wire logic signed [IN_W-1:0] din,
  // clamped value out
  output logic [OUT_W-1:0] dout,
  output logic sat_hi,
  output logic sat_lo
);
  localparam logic signed [IN_W-1:0] HI = SIGNED_OUT ?
    $signed({{(IN_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}}) :
    $signed({{(IN_W-OUT_W){1'b0}}, {OUT_W{1'b1}}});
  localparam logic signed [IN_W-1:0] LO = SIGNED_OUT ?
    $signed({{(IN_W-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}}) :
    $signed({IN_W{1'b0}});

  assign sat_hi = din > HI;
  assign sat_lo = din < LO;
  assign dout = sat_hi ? HI[OUT_W-1:0] : (sat_lo ? LO[OUT_W-1:0] : din[OUT_W-1:0]);
endmodule : ccp_sat

// ### ccp_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module ccp_sync (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : ccp_sync

// ### ccp_conv_model.sv
// behavioural model of the current converter facing the block
`timescale 1ns/1ps
module ccp_conv_model
  import ccp_pkg::*;
#(
  parameter int LAT = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // conversion control from the block
  input wire logic conv_start,
  input wire logic conv_offset,
  // values to report
  input wire logic [ccp_pkg::SAMPLE_W-1:0] meas_data,
  input wire logic [ccp_pkg::SAMPLE_W-1:0] off_data,
  // result to the block
  output ccp_pkg::ccp_conv_res_t conv_res
);
  int cnt;
  logic offs;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      offs <= 1'b0;
      conv_res <= '0;
    end else begin
      conv_res.done <= 1'b0;
      // data not held outside the done cycle
      conv_res.data <= ~conv_res.data;
      if (conv_start) begin
        cnt <= LAT;
        offs <= conv_offset;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_res.done <= 1'b1;
        conv_res.data <= offs ? off_data : meas_data;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : ccp_conv_model

// ### tb.sv
// self-checking testbench for the coulomb counter current path
`timescale 1ns/1ps
module tb;
  import ccp_pkg::*;
  localparam int PER = 200;
  localparam logic [15:0] OFFV = 16'h000A;
  localparam logic [11:0] A_CFG = {2'b00, IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_CUR = {2'b00, IDX_CURRENT, 2'b00};
  localparam logic [11:0] A_ACR = {2'b00, IDX_ACR, 2'b00};
  localparam logic [11:0] A_COB = {2'b00, IDX_CURRENT_OFFSET_BIAS, 2'b00};
  localparam logic [11:0] A_ABR = {2'b00, IDX_ABR, 2'b00};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0;
  logic sleep_req = 1'b0;
  logic [15:0] mdata = '0;
  logic hreadyout;
  logic hresp;
  logic conv_start;
  logic conv_offset;
  logic [31:0] hrdata;
  ccp_conv_res_t conv_res;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  always #5 hclk = ~hclk;

  ccp_core #(.PERIOD_CYC(PER)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_start(conv_start),
    .conv_offset(conv_offset), .conv_res(conv_res), .sleep_req(sleep_req)
  );

  ccp_conv_model #(.LAT(5)) conv (
    .hclk(hclk), .hresetn(hresetn), .conv_start(conv_start), .conv_offset(conv_offset),
    .meas_data(mdata), .off_data(OFFV), .conv_res(conv_res)
  );

  // ********
  // shared tasks
  // ********
  task end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task wait_start(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (conv_start !== 1'b1);
  endtask : wait_start

  function automatic logic [15:0] f_cur(input logic [15:0] d, input logic [7:0] cb);
    int v;
    v = -($signed(d) - $signed(OFFV)) + $signed(cb);
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction : f_cur

  function automatic logic [15:0] f_acr(input logic [15:0] a0, input logic [15:0] cur,
                                        input logic [7:0] ab, input logic nb);
    int c;
    longint f;
    c = $signed(cur);
    if ((c > 0 && c < 64) || (nb && c > -16 && c < 0)) c = 0;
    c = c + $signed(ab & 8'hFC);
    f = longint'(a0) * 16384 + c;
    if (f < 0) f = 0;
    if (f > 64'd1073741823) f = 64'd1073741823;
    return f[29:14];
  endfunction : f_acr

  task meas(input logic [15:0] d, input logic [7:0] cb, input logic [7:0] ab,
            input logic nb, input logic [15:0] a0);
    logic [31:0] r;
    int n;
    ahb(1'b1, A_COB, {24'h0, cb}, r);
    ahb(1'b1, A_ABR, {24'h0, ab}, r);
    ahb(1'b1, A_CFG, {27'h0, nb, 4'h0}, r);
    mdata <= d;
    ahb(1'b1, A_ACR, {16'h0, a0}, r);
    wait_start(n);
    chk({31'h0, conv_offset}, 32'h1);
    wait_start(n);
    chk({31'h0, conv_offset}, 32'h0);
    do @(posedge hclk); while (conv_res.done !== 1'b1);
    ahb(1'b0, A_CUR, 32'h0, r);
    chk(r, {16'h0, f_cur(d, cb)});
    ahb(1'b0, A_ACR, 32'h0, r);
    chk(r, {16'h0, f_acr(a0, f_cur(d, cb), ab, nb)});
  endtask : meas

  // ********
  // scenarios
  // ********
  task t_reset;
    logic [31:0] r;
    ahb(1'b0, A_CFG, 32'h0, r);
    chk(r, 32'h10);
    ahb(1'b0, A_COB, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b0, A_ABR, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b1, A_CUR, 32'h1234, r);
    ahb(1'b0, A_CUR, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b1, 12'h000, 32'hFF, r);
    ahb(1'b0, 12'h000, 32'h0, r);
    chk(r, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task t_sign;
    meas(16'hFF9C, 8'h05, 8'h00, 1'b0, 16'h1000);
    meas(16'h00C8, 8'h00, 8'h00, 1'b0, 16'h1000);
    $display("sign test done");
  endtask : t_sign

  task t_sat;
    meas(16'h8000, 8'h00, 8'h00, 1'b0, 16'hFFFF);
    meas(16'h7FFF, 8'h80, 8'h00, 1'b0, 16'h0000);
    $display("saturation test done");
  endtask : t_sat

  task t_blank;
    logic [31:0] r;
    meas(16'hFFCB, 8'h00, 8'hFF, 1'b1, 16'h0010);
    meas(16'hFFCA, 8'h00, 8'hFF, 1'b1, 16'h0010);
    meas(16'hFFCB, 8'h00, 8'h00, 1'b1, 16'h0010);
    meas(16'h0019, 8'h00, 8'h00, 1'b1, 16'h0010);
    meas(16'h0019, 8'h00, 8'h00, 1'b0, 16'h0010);
    ahb(1'b0, A_ABR, 32'h0, r);
    chk(r, 32'h0);
    $display("blanking test done");
  endtask : t_blank

  task t_sleep;
    logic [31:0] r;
    int n;
    wait_start(n);
    wait_start(n);
    chk(n, PER);
    sleep_req <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b1, A_ACR, 32'h0123, r);
    n = 0;
    repeat (3 * PER) begin
      @(posedge hclk);
      if (conv_start === 1'b1) n++;
    end
    chk(n, 0);
    ahb(1'b0, A_ACR, 32'h0, r);
    chk(r, 32'h0123);
    sleep_req <= 1'b0;
    $display("sleep test done");
  endtask : t_sleep

  // ********
  // main sequence and timeout
  // ********
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_sign;
    t_sat;
    t_blank;
    t_sleep;
    end_sim;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim;
    end
  end
endmodule : tb
